// ---- logic/ltl_fifo.v ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module ltl_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;

  assign out_data = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 1'b1;
    else if (pop & ~push)
      next_count = count - 1'b1;
  end

  always @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH-1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH-1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      count     <= next_count;
      // full and empty kept as flops so the ports are registered
      in_ready  <= (next_count != DEPTH);
      out_valid <= (next_count != 0);
    end
  end
endmodule // ltl_fifo

// ---- logic/ltl_link.v ----
// transceiver-side framer for the serial layer-1 link
`timescale 1ns/10ps
`include "ltl_regs.vh"
module ltl_link #(
  parameter FIFO_DEPTH = `LTL_FIFO_DEPTH,
  parameter FIFO_AW    = 5
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        frame_sync,
  input  wire        link_bit_clock,
  input  wire        link_rx_line,
  output reg         link_tx_line,
  input  wire        stat_line,
  output reg         cmd_line,
  input  wire [1:0]  mode,
  input  wire [1:0]  num_chips,
  input  wire [23:0] line_active,
  input  wire [15:0] tx_data,
  input  wire        tx_valid,
  output wire        tx_ready,
  input  wire [95:0] chip_command_register,
  input  wire [31:0] channel_command_register,
  input  wire [119:0] tx_ram_ctrl,
  output reg  [7:0]  rx_data,
  output reg  [7:0]  rx_echo,
  output reg  [7:0]  rx_fbit,
  output reg  [4:0]  rx_chan,
  output reg         rx_valid,
  output reg  [23:0] chip_status_register,
  output reg  [23:0] chan_slip,
  output reg  [23:0] framing_code_violation_flag,
  output reg  [1:0]  rate_sel,
  output reg         burst_phase,
  output reg         mchan_cv_mark
);
  // a count of zero chips is treated as one
  function [1:0] chips_of;
    input [1:0] n;
    begin
      chips_of = (n == 2'h0) ? 2'h1 : ((n > 2'h3) ? 2'h3 : n);
    end
  endfunction

  function [4:0] chans_of;
    input [1:0] n;
    begin
      chans_of = {chips_of(n), 3'h0};
    end
  endfunction

  // channel word n of a chip maps to absolute channel 8*chip+n-1
  function [4:0] chan_ix;
    input [1:0] chip;
    input [3:0] word;
    begin
      chan_ix = {chip, 3'h0} + {1'b0, word} - 5'h01;
    end
  endfunction

  localparam [31:0] RX_LAG    = `LTL_RX_CH_LAG;
  localparam [31:0] WORD_LAST = `LTL_WORD_BITS - 1;

  // two-flop synchronisers for every pin
  reg  lc_s1, lc_s2, lc_s3;
  reg  fs_s1, fs_s2, fs_s3;
  reg  rx_s1, rx_s2;
  reg  st_s1, st_s2;
  wire lc_rise = lc_s2 & ~lc_s3;
  wire lc_fall = ~lc_s2 & lc_s3;
  wire fs_rise = fs_s2 & ~fs_s3;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lc_s1 <= 1'b0;
      lc_s2 <= 1'b0;
      lc_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_s3 <= 1'b0;
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
      st_s1 <= 1'b0;
      st_s2 <= 1'b0;
    end else begin
      lc_s1 <= link_bit_clock;
      lc_s2 <= lc_s1;
      lc_s3 <= lc_s2;
      fs_s1 <= frame_sync;
      fs_s2 <= fs_s1;
      fs_s3 <= fs_s2;
      rx_s1 <= link_rx_line;
      rx_s2 <= rx_s1;
      st_s1 <= stat_line;
      st_s2 <= st_s1;
    end
  end

  // tx data fifo
  wire [15:0] f_data;
  wire        f_valid;
  wire        f_pop;

  ltl_fifo #(
    .WIDTH (`LTL_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // frame position counters
  reg  [`LTL_POS_W-1:0] pos;
  reg                   frame_pend;
  reg                   started;
  reg  [4:0]            cmd_bit;
  reg  [3:0]            cmd_word;
  reg  [1:0]            cmd_chip;
  reg  [15:0]           cur_word;
  reg  [1:0]            frame_cnt;

  wire       st_mode = (mode != `LTL_MODE_TWO_WIRE);
  wire [4:0] nch     = chans_of(num_chips);

  reg  [`LTL_POS_W-1:0] next_pos;
  reg  [4:0]  next_cmd_bit;
  reg  [3:0]  next_cmd_word;
  reg  [1:0]  next_cmd_chip;
  reg  [6:0]  n_ch;
  reg  [3:0]  n_idx;
  reg         n_in_data;
  reg         n_start;
  reg  [15:0] next_word;
  reg  [2:0]  n_elem;
  reg         n_ctl;
  reg         n_dbit;
  reg         n_fmark;
  reg         next_tx;
  reg  [31:0] cmd_word_val;
  reg  [4:0]  ram_ix;
  reg  [4:0]  ch_abs;

  always @* begin
    next_pos      = frame_pend ? {`LTL_POS_W{1'b0}} : pos + 1'b1;
    next_cmd_bit  = frame_pend ? 5'h00 : cmd_bit + 1'b1;
    next_cmd_word = cmd_word;
    next_cmd_chip = cmd_chip;
    if (frame_pend) begin
      next_cmd_word = 4'h0;
      next_cmd_chip = 2'h0;
    end else if (cmd_bit == WORD_LAST[4:0]) begin
      if (cmd_word == `LTL_WORDS_PER_CHIP - 1) begin
        next_cmd_word = 4'h0;
        if (cmd_chip != 2'h3)
          next_cmd_chip = cmd_chip + 1'b1;
      end else begin
        next_cmd_word = cmd_word + 1'b1;
      end
    end
    // slot is 16 link bits in S/T mode, 8 in two-wire mode
    n_ch      = st_mode ? {1'b0, next_pos[9:4]} : next_pos[9:3];
    n_idx     = st_mode ? next_pos[3:0] : {1'b0, next_pos[2:0]};
    // pending sync lets slot 0 launch on the very rise that opens the frame
    n_in_data = (started | frame_pend) & (n_ch < {2'b00, nch});
    n_start   = n_in_data & (n_idx == 4'h0);
    next_word = n_start ? (f_valid ? f_data : 16'h0000) : cur_word;
    n_elem    = st_mode ? n_idx[3:1] : n_idx[2:0];
    n_ctl     = st_mode & n_idx[0];
    n_dbit    = next_word[3'h7 - n_elem];
    n_fmark   = next_word[4'h8 + {1'b0, 3'h7 - n_elem}];
    ch_abs    = n_ch[4:0];
    if (!n_in_data)
      next_tx = 1'b0;
    else if (!st_mode)
      next_tx = n_dbit & line_active[ch_abs];
    else if (n_ctl)
      next_tx = n_fmark;
    else
      next_tx = n_fmark | n_dbit;
    // channel command word mixes register and tx RAM bits
    ram_ix       = chan_ix(next_cmd_chip, next_cmd_word);
    cmd_word_val = channel_command_register;
    cmd_word_val[`LTL_WRST_POS] = tx_ram_ctrl[ram_ix * `LTL_RAM_BITS];
    cmd_word_val[`LTL_STATE_MACHINE_INIT_FIELD_LSB +: 3] = tx_ram_ctrl[ram_ix * `LTL_RAM_BITS + 1 +: 3];
    cmd_word_val[`LTL_MULTIFRAME_SYNC_BIT_POS] = tx_ram_ctrl[ram_ix * `LTL_RAM_BITS + 4];
    if (next_cmd_word == 4'h0)
      cmd_word_val = chip_command_register[{next_cmd_chip, 5'h00} +: 32];
  end

  // pops only on a link rise at slot start; an empty fifo sends zeros
  assign f_pop = lc_rise & n_start;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos           <= {`LTL_POS_W{1'b1}};
      frame_pend    <= 1'b0;
      started       <= 1'b0;
      cmd_bit       <= 5'h00;
      cmd_word      <= 4'h0;
      cmd_chip      <= 2'h3;
      cur_word      <= 16'h0000;
      link_tx_line  <= 1'b0;
      cmd_line      <= 1'b0;
      frame_cnt     <= 2'h0;
      burst_phase   <= 1'b0;
      mchan_cv_mark <= 1'b0;
      rate_sel      <= 2'h1;
    end else begin
      rate_sel <= chips_of(num_chips);
      if (fs_rise) begin
        frame_pend    <= 1'b1;
        frame_cnt     <= frame_cnt + 1'b1;
        burst_phase   <= ~frame_cnt[0];
        mchan_cv_mark <= (frame_cnt == `LTL_SUPERFRAME_LAST);
      end
      if (lc_rise) begin
        if (frame_pend)
          started <= 1'b1;
        frame_pend   <= fs_rise;
        if (next_pos != {`LTL_POS_W{1'b1}})
          pos <= next_pos;
        cmd_bit      <= next_cmd_bit;
        cmd_word     <= next_cmd_word;
        cmd_chip     <= next_cmd_chip;
        cur_word     <= next_word;
        link_tx_line <= next_tx;
        if ((started | frame_pend) && next_cmd_chip < chips_of(num_chips))
          cmd_line <= cmd_word_val[next_cmd_bit];
        else
          cmd_line <= 1'b0;
      end
    end
  end

  // receive side sampled at the link clock fall
  reg  [7:0]  rx_d;
  reg  [7:0]  rx_c;
  reg  [31:0] stat_sh;
  reg  [6:0]  c_ch;
  reg  [3:0]  c_idx;
  reg  [2:0]  c_elem;
  reg         c_ctl;
  reg         c_in_data;
  reg         c_last;
  reg  [7:0]  d_now;
  reg  [7:0]  c_now;
  reg  [5:0]  rx_ch_full;
  reg  [31:0] stat_now;
  reg  [4:0]  st_ix;

  always @* begin
    c_ch      = st_mode ? {1'b0, pos[9:4]} : pos[9:3];
    c_idx     = st_mode ? pos[3:0] : {1'b0, pos[2:0]};
    c_elem    = st_mode ? c_idx[3:1] : c_idx[2:0];
    c_ctl     = st_mode & c_idx[0];
    c_in_data = started & (c_ch < {2'b00, nch});
    c_last    = st_mode ? (c_idx == 4'hf) : (c_idx == 4'h7);
    d_now     = rx_d;
    c_now     = rx_c;
    if (c_ctl)
      c_now[3'h7 - c_elem] = rx_s2;
    else
      d_now[3'h7 - c_elem] = rx_s2;
    if (!st_mode)
      c_now = 8'h00;
    rx_ch_full = {1'b0, c_ch[4:0]} + RX_LAG[5:0];
    if (rx_ch_full >= {1'b0, nch})
      rx_ch_full = rx_ch_full - {1'b0, nch};
    stat_now = {st_s2, stat_sh[31:1]};
    st_ix    = chan_ix(cmd_chip, cmd_word);
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_d                 <= 8'h00;
      rx_c                 <= 8'h00;
      rx_data              <= 8'h00;
      rx_echo              <= 8'h00;
      rx_fbit              <= 8'h00;
      rx_chan              <= 5'h00;
      rx_valid             <= 1'b0;
      stat_sh              <= 32'h00000000;
      chip_status_register <= 24'h000000;
      chan_slip            <= 24'h000000;
      framing_code_violation_flag <= 24'h000000;
    end else begin
      rx_valid <= 1'b0;
      if (lc_fall) begin
        if (c_in_data) begin
          rx_d <= d_now;
          rx_c <= c_now;
          if (c_last) begin
            rx_data  <= d_now & ~c_now;
            rx_echo  <= c_now & ~d_now;
            rx_fbit  <= c_now & d_now;
            rx_chan  <= rx_ch_full[4:0];
            rx_valid <= 1'b1;
          end
        end
        stat_sh <= stat_now;
        if (started && cmd_bit == WORD_LAST[4:0] && cmd_chip < chips_of(num_chips)) begin
          if (cmd_word == 4'h0)
            chip_status_register[{cmd_chip, 3'h0} +: `LTL_DELAY_W] <=
              stat_now[`LTL_DELAY_LSB +: `LTL_DELAY_W];
          else begin
            // other status bits are transceiver test bits and dropped
            chan_slip[st_ix] <= stat_now[`LTL_SLIP_POS];
            framing_code_violation_flag[st_ix] <= stat_now[`LTL_FRAMING_CODE_VIOLATION_FLAG_POS];
          end
        end
      end
    end
  end
endmodule // ltl_link

// ---- logic/ltl_regs.vh ----
// constants for the layer-1 transceiver link framer
`ifndef LTL_REGS_VH
`define LTL_REGS_VH

`define LTL_FRAME_RATE_HZ   8000
`define LTL_BASE_RATE_KHZ   3072
`define LTL_CH_PER_CHIP     8
`define LTL_MAX_CHIPS       3
`define LTL_WORD_BITS       32
`define LTL_WORDS_PER_CHIP  9
`define LTL_RX_CH_LAG       2
`define LTL_FIFO_WIDTH      16
`define LTL_FIFO_DEPTH      32
`define LTL_POS_W           10

`define LTL_MODE_TWO_WIRE   2'h0
`define LTL_MODE_SUBSCRIBER 2'h1
`define LTL_MODE_TRUNK      2'h2

`define LTL_WRST_POS        0
`define LTL_STATE_MACHINE_INIT_FIELD_LSB       1
`define LTL_MULTIFRAME_SYNC_BIT_POS       4
`define LTL_RAM_BITS        5
`define LTL_DELAY_LSB       0
`define LTL_DELAY_W         8
`define LTL_SLIP_POS        0
`define LTL_FRAMING_CODE_VIOLATION_FLAG_POS        1
`define LTL_SUPERFRAME_LAST 2'h3

`endif

// ---- tb/ltl_far_end.sv ----
// far-end transceiver chip model: link clock, frame sync, receive and status streams
`timescale 1ns/10ps
module ltl_far_end (
  output reg  link_bit_clock,
  output reg  frame_sync,
  output reg  link_rx_line,
  output reg  stat_line,
  input  wire link_tx_line,
  input  wire cmd_line
);
  localparam FRAME_BITS = 390;  // 390 periods of 320 ns, one 124.8 us frame
  localparam [7:0] DELAY = 8'h5a;
  integer    k;
  integer    nframes;
  integer    j;
  reg        txb  [0:511];
  reg        cmdb [0:511];
  reg  [7:0] v;
  function [7:0] rx_byte(input integer ch);
    rx_byte = 8'h96 ^ ch[7:0];
  endfunction
  function [7:0] rx_ctl(input integer ch);
    rx_ctl = {ch[2:0], 5'h09};
  endfunction
  initial begin
    link_bit_clock = 1'b0;
    frame_sync = 1'b0;
    link_rx_line = 1'b0;
    stat_line = 1'b0;
    k = 301;  // leaves time for reset and fifo fill
    nframes = 0;
    #37;
    forever #160 link_bit_clock = ~link_bit_clock;
  end
  always @(negedge link_bit_clock) begin
    k = (k == FRAME_BITS - 1) ? 0 : k + 1;
    frame_sync <= (k == 0);
  end
  // bits change after a rise so the controller finds them settled at the fall
  always @(posedge link_bit_clock) begin
    if (k > 0) begin
      txb[k-1] = link_tx_line;
      cmdb[k-1] = cmd_line;
    end
    if (k == 300) nframes = nframes + 1;
    j = (k / 16 + 2) % 8;
    v = k[0] ? rx_ctl(j) : rx_byte(j);
    // slot c carries channel c+2, data before control
    link_rx_line <= (k < 128) ? v[7 - (k % 16) / 2] : ~link_rx_line;
    j = (k - 32) / 32;
    // chip word, then channel m: slip m[0], framing_code_violation_flag m[1], LSB first
    if (k < 32) stat_line <= (k < 8) ? DELAY[k] : 1'b0;
    else if (k < 288) stat_line <= ((k % 32) < 2) ? j[k % 32] : 1'b0;
    else stat_line <= ~stat_line;
  end
endmodule // ltl_far_end

// ---- tb/ltl_link_asserts.sv ----
// port timing checks for the link framer
`timescale 1ns/10ps
module ltl_link_asserts (
  input wire       clk,
  input wire       resetn,
  input wire       frame_sync,
  input wire       link_bit_clock,
  input wire       link_tx_line,
  input wire       cmd_line,
  input wire [1:0] num_chips,
  input wire [4:0] rx_chan,
  input wire       rx_valid,
  input wire [1:0] rate_sel,
  input wire       burst_phase,
  input wire       mchan_cv_mark
);
  reg        lck_d;
  reg        fs_d;
  reg        seen;
  reg  [4:0] rise_age;
  reg  [4:0] fs_age;
  reg  [4:0] last_chan;
  wire [4:0] nch = (num_chips == 2'h0) ? 5'h08 : {num_chips, 3'h0};
  // ages saturate so a long idle never wraps into a false match
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lck_d <= 1'b0;
      fs_d <= 1'b0;
      seen <= 1'b0;
      rise_age <= 5'h1f;
      fs_age <= 5'h1f;
      last_chan <= 5'h00;
    end else begin
      lck_d <= link_bit_clock;
      fs_d <= frame_sync;
      rise_age <= (link_bit_clock & ~lck_d) ? 5'h00 : rise_age + {4'h0, ~&rise_age};
      fs_age <= (frame_sync & ~fs_d) ? 5'h00 : fs_age + {4'h0, ~&fs_age};
      if (rx_valid) begin
        seen <= 1'b1;
        last_chan <= rx_chan;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rx_gap;
    (!rx_valid) [*8];
  endsequence
  AST_TX_AT_RISE: assert property ($changed(link_tx_line) |-> rise_age <= 5'h06)
    else $error("tx bit moved off a link clock rise");
  AST_CMD_AT_RISE: assert property ($changed(cmd_line) |-> rise_age <= 5'h06)
    else $error("cmd bit moved off a link clock rise");
  AST_RATE_FOLLOWS: assert property ($stable(num_chips) |-> rate_sel == nch[4:3])
    else $error("rate request differs from chip count");
  AST_RX_GAP: assert property (rx_valid |=> s_rx_gap)
    else $error("receive slots too close");
  AST_RX_ORDER: assert property (rx_valid && seen |-> rx_chan == (last_chan + 5'h01) % nch)
    else $error("receive channel out of order");
  AST_RX_RANGE: assert property (rx_valid |-> rx_chan < nch)
    else $error("receive channel beyond attached chips");
  AST_BURST_TOGGLES: assert property ($rose(frame_sync) |-> ##[1:24] $changed(burst_phase))
    else $error("burst phase missed a frame");
  AST_CV_AT_FRAME: assert property ($changed(mchan_cv_mark) |-> fs_age <= 5'h14)
    else $error("violation mark moved off frame start");
endmodule // ltl_link_asserts
bind ltl_link ltl_link_asserts chk (.clk, .resetn, .frame_sync, .link_bit_clock, .link_tx_line,
  .cmd_line, .num_chips, .rx_chan, .rx_valid, .rate_sel, .burst_phase, .mchan_cv_mark);

// ---- tb/ltl_link_tb.sv ----
// self-checking bench for the link framer
`timescale 1ns/10ps
module ltl_link_tb;
  reg          clk;
  reg          resetn;
  reg  [1:0]   mode;
  reg  [1:0]   num_chips;
  reg  [23:0]  line_active;
  reg  [15:0]  tx_data;
  reg          tx_valid;
  reg  [95:0]  chip_command_register;
  reg  [31:0]  channel_command_register;
  reg  [119:0] tx_ram_ctrl;
  wire         frame_sync, link_bit_clock, link_rx_line, link_tx_line, stat_line, cmd_line;
  wire         tx_ready, rx_valid, burst_phase, mchan_cv_mark;
  wire [7:0]   rx_data, rx_echo, rx_fbit;
  wire [4:0]   rx_chan;
  wire [23:0]  chip_status_register, chan_slip, framing_code_violation_flag;
  wire [1:0]   rate_sel;
  reg  [23:0]  got [0:23];
  reg  [15:0]  wq [0:63];
  reg  [31:0]  x, g;
  integer      fail_count, samples_checked, pn, i, j;

  ltl_link dut (.clk, .resetn, .frame_sync, .link_bit_clock, .link_rx_line, .link_tx_line,
    .stat_line, .cmd_line, .mode, .num_chips, .line_active, .tx_data, .tx_valid, .tx_ready,
    .chip_command_register, .channel_command_register, .tx_ram_ctrl, .rx_data, .rx_echo,
    .rx_fbit, .rx_chan, .rx_valid, .chip_status_register, .chan_slip,
    .framing_code_violation_flag, .rate_sel, .burst_phase, .mchan_cv_mark);
  ltl_far_end far (.link_bit_clock, .frame_sync, .link_rx_line, .stat_line, .link_tx_line,
    .cmd_line);

  task chk(input [31:0] exp, input [31:0] seen, input string nm);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // called at a falling edge, returns at the falling edge after acceptance
  task push(input [15:0] w);
    integer t;
    tx_data = w;
    tx_valid = 1'b1;
    wq[pn] = w;
    pn = pn + 1;
    t = 0;
    @(posedge clk);
    while (tx_ready !== 1'b1 && t < 50) begin
      t = t + 1;
      @(posedge clk);
    end
    if (t >= 50 && tx_ready !== 1'b1) fail_count = fail_count + 1;
    @(negedge clk);
  endtask
  task chk_st(input integer f);
    integer c, e;
    for (c = 0; c < 8; c = c + 1) begin
      x = 32'h0;
      g = 32'h0;
      for (e = 0; e < 8; e = e + 1) begin
        x[2*e] = wq[f+c][7-e] | wq[f+c][15-e];
        x[2*e+1] = wq[f+c][15-e];
        g[2*e] = far.txb[16*c+2*e];
        g[2*e+1] = far.txb[16*c+2*e+1];
      end
      chk(x, g, "st slot");
    end
  endtask
  task chk_2w(input integer f, input integer n);
    integer c, e;
    for (c = 0; c < n; c = c + 1) begin
      x = line_active[c] ? {24'h0, wq[f+c][7:0]} : 32'h0;
      g = 32'h0;
      for (e = 0; e < 8; e = e + 1) g[7-e] = far.txb[8*c+e];
      chk(x, g, "two wire slot");
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    if (rx_valid === 1'b1) got[rx_chan] <= {rx_data, rx_echo, rx_fbit};
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #1_000_000;  // four frames need about 500 us
    fail_count = fail_count + 1;
    end_of_test;
  end
  initial begin
    fail_count = 0;
    samples_checked = 0;
    pn = 0;
    resetn = 1'b0;
    mode = 2'h2;  // trunk side first: every mode but two-wire has echo pairs
    num_chips = 2'h1;
    line_active = 24'hf05a3c;
    tx_data = 16'h0;
    tx_valid = 1'b0;
    chip_command_register = {64'h0, 32'hc3a5_0f17};
    channel_command_register = 32'h8421_7be0;
    tx_ram_ctrl = {80'h0, 40'h9a_7c31_e85b};
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    for (i = 0; i < 8; i = i + 1) push({(i == 0) ? 8'h80 : 8'h00, 8'h35 ^ 8'(i)});
    tx_valid = 1'b0;
    while (far.nframes < 1) @(negedge clk);
    chk_st(0);
    for (i = 0; i < 32; i = i + 1) g[i] = far.cmdb[i];
    chk(chip_command_register[31:0], g, "chip cmd");
    for (j = 0; j < 8; j = j + 1) begin
      for (i = 0; i < 32; i = i + 1) g[i] = far.cmdb[32+32*j+i];
      chk({channel_command_register[31:5], tx_ram_ctrl[5*j+:5]}, g, "chan cmd");
      x = {8'h0, far.rx_byte(j) & ~far.rx_ctl(j), far.rx_ctl(j) & ~far.rx_byte(j),
        far.rx_byte(j) & far.rx_ctl(j)};
      g = {8'h0, got[j]};
      chk(x, g, "rx pairs");
    end
    chk(32'h005aaacc, {8'h0, chip_status_register[7:0], chan_slip[7:0],
      framing_code_violation_flag[7:0]}, "status");
    chk(32'h1, {30'h0, rate_sel}, "rate");
    chk(32'h1, {31'h0, burst_phase}, "burst phase");
    chk(32'h0, {31'h0, mchan_cv_mark}, "cv mark");
    mode = 2'h0;
    num_chips = 2'h3;
    while (tx_ready === 1'b1 && pn < 60) push({8'h00, 8'(pn * 7)});
    tx_valid = 1'b0;
    chk(32'h28, pn, "fill count");
    while (far.nframes < 2) @(negedge clk);
    chk_2w(8, 24);
    chk(32'h3, {30'h0, rate_sel}, "rate");
    chk(32'h0, {31'h0, burst_phase}, "burst phase");
    mode = 2'h1;
    num_chips = 2'h1;
    while (far.nframes < 3) @(negedge clk);
    chk_st(32);
    chk(32'h1, {31'h0, tx_ready}, "drained");
    while (far.nframes < 4) @(negedge clk);
    chk(32'h1, {31'h0, mchan_cv_mark}, "cv mark");
    chk(32'h0, {31'h0, burst_phase}, "burst phase");
    end_of_test;
  end
endmodule // ltl_link_tb
